// file: verilog/bssb_defines.vh
// Constants shared by the bank-select and subtract-with-borrow execute block.
`ifndef BSSB_DEFINES_VH
`define BSSB_DEFINES_VH
`define BSSB_OP_SEL_BANK0 8'h4f
`define BSSB_OP_SEL_BANK1 8'h5f
`define BSSB_OP_SBC_RR 8'h32
`define BSSB_OP_SBC_RIR 8'h33
`define BSSB_OP_SBC_GG 8'h34
`define BSSB_OP_SBC_GIR 8'h35
`define BSSB_OP_SBC_GIM 8'h36
`define BSSB_CYC_SHORT 3'h4
`define BSSB_CYC_LONG 3'h6
`define BSSB_FLAG_BANK 0
`define BSSB_FLAG_H 2
`define BSSB_FLAG_D 3
`define BSSB_FLAG_V 4
`define BSSB_FLAG_S 5
`define BSSB_FLAG_Z 6
`define BSSB_FLAG_C 7
`define BSSB_FLAGS_RESET 8'h00
`define BSSB_REG_FLAGS 32'h0000_0000
`define BSSB_REG_STATUS 32'h0000_0004
`define BSSB_REG_SET1 32'h0000_0008
`endif

// file: verilog/bssb_sub_core.v
// Combinational subtract-with-borrow core and its flag results.
`timescale 1ns/10ps
`default_nettype none
module bssb_sub_core #(
  parameter W = 8
) (
  input wire [W-1:0] dst_i,
  input wire [W-1:0] src_i,
  input wire carry_i,
  output wire [W-1:0] res_o,
  output wire c_o,
  output wire z_o,
  output wire s_o,
  output wire v_o,
  output wire h_o
);
  // Two's complement of source plus incoming borrow: dst + ~src + !c.
  wire [W:0] sum;
  wire [4:0] low;
  assign sum = {1'b0, dst_i} + {1'b0, ~src_i} + {{W{1'b0}}, ~carry_i};
  assign low = {1'b0, dst_i[3:0]} + {1'b0, ~src_i[3:0]} + {4'h0, ~carry_i};
  assign res_o = sum[W-1:0];
  assign c_o = ~sum[W];
  assign z_o = (sum[W-1:0] == {W{1'b0}});
  assign s_o = sum[W-1];
  assign v_o = (dst_i[W-1] != src_i[W-1]) && (sum[W-1] == src_i[W-1]);
  assign h_o = ~low[4];
endmodule // bssb_sub_core
`default_nettype wire

// file: verilog/bssb_exec.v
// Execute stage for select-bank and subtract-with-borrow, with a Wishbone view.
//
// What this block does
// - Opcode 4f clears bank bit in four cycles.
// - Opcode 5f sets bank bit in four cycles.
// - Bank selects leave all arithmetic flags unchanged.
// - Bank one addresses only when second bank exists.
// - Subtract with borrow writes dst, source untouched.
// - Subtract by adding complemented source plus inverted borrow.
// - Carry set when a borrow occurs.
// - Zero set when all result bits zero.
// - Sign follows result bit seven.
// - Overflow on opposite signs, result matches source.
// - Decimal-adjust flag always set by subtraction.
// - Half-carry cleared on carry out of bit three.
`timescale 1ns/10ps
`default_nettype none
`include "bssb_defines.vh"
module bssb_exec #(
  parameter HAS_BANK1 = 1
) (
  input wire mclk_i,
  input wire reset_i,
  input wire issue_i,
  input wire [7:0] opcode_i,
  input wire [7:0] dst_val_i,
  input wire [7:0] src_val_i,
  input wire set1_req_i,
  input wire [7:0] set1_addr_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg dst_we_o,
  output reg [7:0] dst_data_o,
  output reg [7:0] flags_o,
  output reg set1_req_o,
  output reg [7:0] set1_addr_o,
  output reg set1_bank_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;

  // Decodes opcodes 32 to 36; shared by the flag update and the write-back in the done state.
  function is_sbc;
    input [7:0] op;
    begin
      is_sbc = (op >= `BSSB_OP_SBC_RR) && (op <= `BSSB_OP_SBC_GIM);
    end
  endfunction

  // Length of each known opcode in cycles, issue cycle included; zero marks an unknown one.
  // Acceptance and the countdown both come from here, so they cannot disagree.
  function [2:0] op_cycles;
    input [7:0] code;
    begin
      case (code)
        `BSSB_OP_SEL_BANK0: begin
          op_cycles = `BSSB_CYC_SHORT;
        end
        `BSSB_OP_SEL_BANK1: begin
          op_cycles = `BSSB_CYC_SHORT;
        end
        `BSSB_OP_SBC_RR: begin
          op_cycles = `BSSB_CYC_SHORT;
        end
        `BSSB_OP_SBC_RIR: begin
          op_cycles = `BSSB_CYC_LONG;
        end
        `BSSB_OP_SBC_GG: begin
          op_cycles = `BSSB_CYC_LONG;
        end
        `BSSB_OP_SBC_GIR: begin
          op_cycles = `BSSB_CYC_LONG;
        end
        `BSSB_OP_SBC_GIM: begin
          op_cycles = `BSSB_CYC_LONG;
        end
        default: begin
          op_cycles = 3'h0;
        end
      endcase
    end
  endfunction

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] cnt;
  reg [7:0] op;
  reg [7:0] dst_q;
  reg [7:0] src_q;
  reg [7:0] next_flags;
  reg bank_eff;
  reg [2:0] next_cnt;
  reg [7:0] next_op;
  reg [7:0] next_dst;
  reg [7:0] next_src;
  reg next_busy;
  reg next_done;
  reg next_illegal;
  reg next_dst_we;
  reg [7:0] next_dst_data;
  reg [31:0] next_wb_dat;
  reg next_wb_ack;
  reg next_set1_req;
  reg [7:0] next_set1_addr;
  reg next_set1_bank;
  wire [7:0] res;
  wire f_c;
  wire f_z;
  wire f_s;
  wire f_v;
  wire f_h;
  wire known_op;
  wire wb_req;

  assign known_op = (op_cycles(opcode_i) != 3'h0);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // The subtractor works on operands captured at issue, so the register file may move on.
  bssb_sub_core #(
    .W(8)
  ) u_core (
    .dst_i(dst_q),
    .src_i(src_q),
    .carry_i(flags_o[`BSSB_FLAG_C]),
    .res_o(res),
    .c_o(f_c),
    .z_o(f_z),
    .s_o(f_s),
    .v_o(f_v),
    .h_o(f_h)
  );

  // The countdown is loaded at issue, so the run state leaves when it reaches one.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue_i && known_op) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cnt == 3'h1) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Flags after the finishing cycle of the instruction held in op.
  always @* begin
    next_flags = flags_o;
    case (op)
      `BSSB_OP_SEL_BANK0: begin
        next_flags[`BSSB_FLAG_BANK] = 1'b0;
      end
      `BSSB_OP_SEL_BANK1: begin
        next_flags[`BSSB_FLAG_BANK] = 1'b1;
      end
      default: begin
        if (is_sbc(op)) begin
          next_flags[`BSSB_FLAG_C] = f_c;
          next_flags[`BSSB_FLAG_Z] = f_z;
          next_flags[`BSSB_FLAG_S] = f_s;
          next_flags[`BSSB_FLAG_V] = f_v;
          next_flags[`BSSB_FLAG_D] = 1'b1;
          next_flags[`BSSB_FLAG_H] = f_h;
        end
      end
    endcase
  end

  // Bank 1 is only reachable when the second bank is built in.
  always @* begin
    bank_eff = (HAS_BANK1 != 0) && flags_o[`BSSB_FLAG_BANK];
  end

  // Next values of the execute registers. An issue with an unknown opcode leaves them all
  // untouched apart from the illegal pulse; an issue made while busy is ignored, with no pulse.
  always @* begin
    next_cnt = cnt;
    next_op = op;
    next_dst = dst_q;
    next_src = src_q;
    next_busy = busy_o;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_dst_we = 1'b0;
    next_dst_data = dst_data_o;
    case (state)
      ST_IDLE: begin
        if (issue_i) begin
          if (known_op) begin
            next_op = opcode_i;
            next_dst = dst_val_i;
            next_src = src_val_i;
            next_busy = 1'b1;
            // The issue cycle counts as the first of the instruction.
            next_cnt = op_cycles(opcode_i) - 3'h2;
          end else begin
            next_illegal = 1'b1;
          end
        end
      end
      ST_RUN: begin
        next_cnt = cnt - 3'h1;
      end
      ST_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        // Only a subtract writes back; the bank selects touch the flags alone.
        if (is_sbc(op)) begin
          next_dst_we = 1'b1;
          next_dst_data = res;
        end
      end
      default: begin
        next_busy = 1'b0;
      end
    endcase
  end

  // Sequencing registers: state, countdown and the operands captured at issue.
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      op <= 8'h00;
      dst_q <= 8'h00;
      src_q <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      dst_q <= next_dst;
      src_q <= next_src;
    end
  end

  // Port registers. The flags change only in the finishing cycle, so a subtract reads
  // the carry left by the instruction before it, never a half-updated one.
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_o <= `BSSB_FLAGS_RESET;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      dst_we_o <= 1'b0;
      dst_data_o <= 8'h00;
    end else begin
      busy_o <= next_busy;
      done_o <= next_done;
      illegal_o <= next_illegal;
      dst_we_o <= next_dst_we;
      dst_data_o <= next_dst_data;
      if (state == ST_DONE) begin
        flags_o <= next_flags;
      end
    end
  end

  // Set 1 address path; registered so a request after done sees the new bank.
  always @* begin
    next_set1_req = set1_req_i;
    next_set1_addr = set1_addr_i;
    next_set1_bank = bank_eff;
  end

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      set1_req_o <= 1'b0;
      set1_addr_o <= 8'h00;
      set1_bank_o <= 1'b0;
    end else begin
      set1_req_o <= next_set1_req;
      set1_addr_o <= next_set1_addr;
      set1_bank_o <= next_set1_bank;
    end
  end

  // Register map seen by software. All words are read-only: a write is acknowledged
  // and dropped, and an unmapped address reads zero.
  function [31:0] reg_read;
    input [31:0] adr;
    input [7:0] flags;
    input [2:0] count;
    input [2:0] pulses;
    input bank;
    input [7:0] addr;
    begin
      case (adr)
        `BSSB_REG_FLAGS: begin
          reg_read = {24'h000000, flags};
        end
        `BSSB_REG_STATUS: begin
          reg_read = {24'h000000, count, 2'b00, pulses};
        end
        `BSSB_REG_SET1: begin
          reg_read = {23'h000000, bank, addr};
        end
        default: begin
          reg_read = 32'h0000_0000;
        end
      endcase
    end
  endfunction

  // Ack comes one cycle after the strobe. The request term masks itself while ack
  // stands, so a strobe still high in the ack cycle gets no second ack; a strobe held one cycle past it is acked again.
  always @* begin
    next_wb_ack = wb_req;
    next_wb_dat = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      next_wb_dat = reg_read(wb_adr_i, flags_o, cnt, {illegal_o, done_o, busy_o},
                             bank_eff, set1_addr_o);
    end
  end

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_wb_ack;
      wb_dat_o <= next_wb_dat;
    end
  end
endmodule // bssb_exec
`default_nettype wire

// file: test/bssb_exec_properties.sv
// Concurrent checks on the execute block's instruction and flag ports.
`timescale 1ns/10ps
`default_nettype none
module bssb_exec_properties (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic issue_i,
  input wire logic [7:0] opcode_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic dst_we_o,
  input wire logic [7:0] dst_data_o,
  input wire logic [7:0] flags_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire go = issue_i && !busy_o;
  sequence run4;
    ##1 busy_o [*3] ##1 done_o;
  endsequence
  sequence run6;
    ##1 busy_o [*5] ##1 done_o;
  endsequence
  bank_zero_a: assert property (go && opcode_i == 8'h4f |-> run4 ##0 !flags_o[0])
    else $error("bank clear wrong");
  bank_one_a: assert property (go && opcode_i == 8'h5f |-> run4 ##0 flags_o[0])
    else $error("bank set wrong");
  bank_keep_a: assert property (go && (opcode_i | 8'h10) == 8'h5f |->
    ##4 flags_o[7:1] == $past(flags_o[7:1], 4)) else $error("bank select moved flags");
  sbc_short_a: assert property (go && opcode_i == 8'h32 |-> run4 ##0 dst_we_o)
    else $error("short subtract timing");
  sbc_long_a: assert property (go && opcode_i > 8'h32 && opcode_i < 8'h37
    |-> run6 ##0 dst_we_o) else $error("long subtract timing");
  we_done_a: assert property (dst_we_o |-> done_o) else $error("write without done");
  dec_flag_a: assert property (dst_we_o |-> flags_o[3]) else $error("decimal flag low");
  zero_flag_a: assert property (dst_we_o |-> flags_o[6] == (dst_data_o == 8'h00))
    else $error("zero flag wrong");
  sign_flag_a: assert property (dst_we_o |-> flags_o[5] == dst_data_o[7])
    else $error("sign flag wrong");
endmodule // bssb_exec_properties
bind bssb_exec bssb_exec_properties bssb_exec_properties_i (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .issue_i(issue_i),
  .opcode_i(opcode_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .dst_we_o(dst_we_o),
  .dst_data_o(dst_data_o),
  .flags_o(flags_o)
);
`default_nettype wire

// file: test/bssb_exec_tb.sv
// Self-checking bench for the bank-select and subtract-with-borrow block.
`timescale 1ns/10ps
`default_nettype none
module bssb_exec_tb;
  logic mclk_i = 0, reset_i = 1, issue_i = 0, set1_req_i = 0;
  logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [7:0] opcode_i = 0, dst_val_i = 0, src_val_i = 0, set1_addr_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_ack_o, busy_o, done_o, illegal_o, dst_we_o, set1_req_o, set1_bank_o;
  logic [7:0] dst_data_o, flags_o, set1_addr_o;
  int error_cnt = 0, checks = 0;
  always #2 mclk_i = ~mclk_i;
  bssb_exec bssb_exec_i (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .issue_i(issue_i),
    .opcode_i(opcode_i),
    .dst_val_i(dst_val_i),
    .src_val_i(src_val_i),
    .set1_req_i(set1_req_i),
    .set1_addr_i(set1_addr_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy_o(busy_o),
    .done_o(done_o),
    .illegal_o(illegal_o),
    .dst_we_o(dst_we_o),
    .dst_data_o(dst_data_o),
    .flags_o(flags_o),
    .set1_req_o(set1_req_o),
    .set1_addr_o(set1_addr_o),
    .set1_bank_o(set1_bank_o)
  );
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Waits for ack (which 0) or done (which 1); a hang counts as a mismatch and ends the run.
  task automatic wait_hi(input int which, output int i);
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (((which == 0) ? wb_ack_o : done_o) !== 1'b1 && i < 20);
    if (((which == 0) ? wb_ack_o : done_o) !== 1'b1) begin
      error_cnt++;
      final_report;
    end
  endtask
  task automatic wb(logic [31:0] a, logic w, logic [31:0] e);
    int i;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= 32'h0000_00ff;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wait_hi(0, i);
    if (!w) chk("wb_dat", wb_dat_o, e);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge mclk_i);
  endtask
  task automatic run(logic [7:0] op, logic [7:0] d, logic [7:0] s, int n);
    int i;
    opcode_i <= op;
    dst_val_i <= d;
    src_val_i <= s;
    issue_i <= 1;
    @(posedge mclk_i);
    issue_i <= 0;
    wait_hi(1, i);
    chk("cycles", i, n);
  endtask
  task automatic t_bank(logic [7:0] op, logic b);
    logic [7:0] f;
    f = flags_o;
    run(op, 8'h00, 8'h00, 4);
    chk("flags", flags_o, {f[7:1], b});
    set1_req_i <= 1;
    set1_addr_i <= 8'h5a;
    repeat (2) @(posedge mclk_i);
    chk("set1", {set1_req_o, set1_addr_o, set1_bank_o}, {1'b1, 8'h5a, b});
    set1_req_i <= 0;
  endtask
  // Expected flags come from a 9-bit difference so the borrow is bit 8.
  task automatic t_sbc(logic [7:0] op, logic [7:0] d, logic [7:0] s);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] f;
    f = flags_o;
    r = {1'b0, d} - s - f[7];
    h = {1'b0, d[3:0]} - s[3:0] - f[7];
    run(op, d, s, op == 8'h32 ? 4 : 6);
    chk("result", {dst_we_o, dst_data_o}, {1'b1, r[7:0]});
    chk("sbc_flags", flags_o, {r[8], r[7:0] == 8'h00, r[7],
      d[7] != s[7] && r[7] == s[7], 1'b1, h[4], 1'b0, f[0]});
  endtask
  task automatic t_refuse;
    logic [7:0] f;
    f = flags_o;
    opcode_i <= 8'h77;
    issue_i <= 1;
    @(posedge mclk_i);
    issue_i <= 0;
    @(posedge mclk_i);
    chk("illegal", {illegal_o, flags_o}, {1'b1, f});
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 0;
    wb(32'h0000_0000, 0, 32'h0000_0000);
    t_bank(8'h5f, 1);
    wb(32'h0000_0008, 0, 32'h0000_015a);
    t_sbc(8'h32, 8'h10, 8'h03);
    t_sbc(8'h33, 8'h03, 8'h10);
    t_sbc(8'h34, 8'h20, 8'h03);
    t_sbc(8'h35, 8'h80, 8'h01);
    t_sbc(8'h36, 8'h01, 8'h01);
    t_bank(8'h4f, 0);
    wb(32'h0000_0008, 0, 32'h0000_005a);
    wb(32'h0000_0000, 1, 32'h0000_0000);
    wb(32'h0000_0000, 0, 32'h0000_0048);
    wb(32'h0000_0040, 0, 32'h0000_0000);
    t_refuse;
    wb(32'h0000_0004, 0, 32'h0000_0000);
    final_report;
  end
endmodule // bssb_exec_tb
`default_nettype wire
